// [core/ils_pkg.sv]
// Constants and carrier types for the lane status and link ident bank
package ils_pkg;

  localparam int NUM_LINKS  = 2;
  localparam int LINK_W     = 1;
  localparam int NUM_LANES  = 5;
  localparam int FIRST_LANE = 3;
  localparam int REG_W      = 8;
  localparam int CHK_W      = 8;
  localparam int IDENT_W    = 5;
  localparam int PAGE_W     = 1;
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 32;
  localparam int IDX_W      = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE     = 12'h300;
  localparam logic [IDX_W-1:0] IDX_DEV_IDENT     = 12'h450;
  localparam logic [IDX_W-1:0] IDX_BANK_IDENT    = 12'h451;
  localparam logic [IDX_W-1:0] IDX_DEFRAMER_CTRL = 12'h475;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 12'h480;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 12'h481;

  // Per lane, lanes 3 to 7 in order
  localparam logic [IDX_W-1:0] IDX_RX_CHK [NUM_LANES] =
    '{12'h425, 12'h42D, 12'h435, 12'h43D, 12'h445};
  localparam logic [IDX_W-1:0] IDX_CALC_CHK [NUM_LANES] =
    '{12'h426, 12'h42E, 12'h436, 12'h43E, 12'h446};
  localparam logic [IDX_W-1:0] IDX_RX_IDENT [NUM_LANES] =
    '{12'h422, 12'h42A, 12'h432, 12'h43A, 12'h442};

  localparam int DFR_SRST_BIT = 3;

  localparam logic [REG_W-1:0]   RST_DEV_IDENT  = 8'h00;
  localparam logic [REG_W-1:0]   RST_BANK_IDENT = 8'h00;
  localparam logic [PAGE_W-1:0]  RST_LINK_PAGE  = 1'h0;
  localparam logic               RST_DFR_SRST   = 1'h1;

  // Interrupt status and mask layout
  localparam int ST_W        = 3;
  localparam int ST_CAPTURE  = 0;
  localparam int ST_MISMATCH = 1;
  localparam int ST_BID_LATE = 2;
  localparam logic [ST_W-1:0] RST_IRQ_MASK = 3'h0;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ils_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } ils_apb_rsp_t;

  typedef struct packed {
    logic               valid;
    logic [LINK_W-1:0]  link;
    logic [CHK_W-1:0]   rx_chk;
    logic [CHK_W-1:0]   calc_chk;
    logic [IDENT_W-1:0] ident;
  } ils_lane_cfg_t;

  typedef struct packed {
    logic [CHK_W-1:0]   rx_chk;
    logic [CHK_W-1:0]   calc_chk;
    logic [IDENT_W-1:0] ident;
  } ils_lane_rec_t;

  typedef ils_lane_rec_t [NUM_LINKS-1:0] ils_lane_bank_t;

endpackage

// [core/ils_lane_capture.sv]
// Per-lane capture of alignment sequence checksums and lane ident, banked per link
`timescale 1ns/10ps
module ils_lane_capture (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire ils_pkg::ils_lane_cfg_t  cfg,
  output ils_pkg::ils_lane_bank_t      rec,
  output logic                         captured,
  output logic                         mismatch
);

  typedef struct packed {
    ils_pkg::ils_lane_bank_t rec;
    logic                    captured;
    logic                    mismatch;
  } ils_cap_state_t;

  ils_cap_state_t s_q;
  ils_cap_state_t s_d;

  always_comb begin
    s_d          = s_q;
    s_d.captured = 1'b0;
    s_d.mismatch = 1'b0;
    // Fields move only when a lane delivers its configuration
    if (cfg.valid) begin                                    // R9
      s_d.rec[cfg.link].rx_chk   = cfg.rx_chk;              // R1
      s_d.rec[cfg.link].calc_chk = cfg.calc_chk;            // R2
      s_d.rec[cfg.link].ident    = cfg.ident;               // R3
      s_d.captured               = 1'b1;
      s_d.mismatch               = (cfg.rx_chk != cfg.calc_chk);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;                                            // R1
    end else begin
      s_q <= s_d;
    end
  end

  assign rec      = s_q.rec;
  assign captured = s_q.captured;
  assign mismatch = s_q.mismatch;

endmodule

// [core/ils_lane_status.sv]
// Lane status and link ident register bank behind an APB slave
// Function
// [R1] Each of lanes 3 to 7 keeps the received alignment checksum in a read-only byte, reset zero.
// [R2] Each of lanes 3 to 7 shows the locally computed checksum in its own read-only byte.
// [R3] Each of lanes 3 to 7 shows the received lane ident in bits 4:0, bits 7:5 read zero.
// [R4] Every register of the group is banked per link, the copy chosen by the page at 0x300.
// [R5] A read/write device ident byte at 0x450 resets to zero.
// [R6] A read/write bank ident byte at 0x451 resets to zero.
// [R7] Software writes the bank ident only while the deframer soft reset (0x475 bit 3) is held.
// [R8] Software leaves the bank ident alone once the deframer runs.
// [R9] Lane fields change only when that lane's configuration arrives and hold otherwise.
`timescale 1ns/10ps
module ils_lane_status (
  input  wire logic                                         SYS_CLK,
  input  wire logic                                         RST,
  input  wire ils_pkg::ils_apb_req_t                        APB_REQ,
  output ils_pkg::ils_apb_rsp_t                             APB_RSP,
  input  wire ils_pkg::ils_lane_cfg_t [ils_pkg::NUM_LANES-1:0] LANE_CFG,
  output logic [ils_pkg::NUM_LINKS-1:0][ils_pkg::REG_W-1:0] LINK_DEV_IDENT,
  output logic [ils_pkg::NUM_LINKS-1:0][ils_pkg::REG_W-1:0] LINK_BANK_IDENT,
  output logic                                              QUAD_BYTE_DEFRAMER_SOFT_RESET,
  output logic                                              IRQ
);

  typedef struct packed {
    logic                                           ack;
    logic [ils_pkg::DATA_W-1:0]                     rdata;
    logic                                           slverr;
    logic [ils_pkg::PAGE_W-1:0]                     page;
    logic [ils_pkg::NUM_LINKS-1:0][ils_pkg::REG_W-1:0] dev_id;
    logic [ils_pkg::NUM_LINKS-1:0][ils_pkg::REG_W-1:0] bank_id;
    logic                                           dfr_srst;
    logic [ils_pkg::ST_W-1:0]                       status;
    logic [ils_pkg::ST_W-1:0]                       mask;
  } ils_state_t;

  ils_state_t s_q;
  ils_state_t s_d;

  ils_pkg::ils_lane_bank_t         lane_rec [ils_pkg::NUM_LANES];
  logic [ils_pkg::NUM_LANES-1:0]   lane_cap;
  logic [ils_pkg::NUM_LANES-1:0]   lane_mis;

  logic [ils_pkg::IDX_W-1:0]       idx;
  logic                            aligned;
  logic                            access;
  logic                            first_acc;
  logic                            done;
  logic [ils_pkg::DATA_W-1:0]      rd_val;
  logic                            rd_hit;
  logic [3:0]                      m_rx;
  logic [3:0]                      m_calc;
  logic [3:0]                      m_id;
  logic [ils_pkg::ST_W-1:0]        ev;
  logic [ils_pkg::ST_W-1:0]        clr;

  // Returns {hit, lane slot} for an index against a per-lane table
  function automatic logic [3:0] lane_match(
    input logic [ils_pkg::IDX_W-1:0] i_idx,
    input logic [ils_pkg::IDX_W-1:0] tbl [ils_pkg::NUM_LANES]
  );
    logic [3:0] r;
    r = 4'h0;
    for (int n = 0; n < ils_pkg::NUM_LANES; n++) begin
      if (i_idx == tbl[n]) begin
        r = {1'b1, 3'(n)};
      end
    end
    return r;
  endfunction

  // Zero-extend a byte into the bus word
  function automatic logic [ils_pkg::DATA_W-1:0] widen(
    input logic [ils_pkg::REG_W-1:0] v
  );
    return {{(ils_pkg::DATA_W-ils_pkg::REG_W){1'b0}}, v};
  endfunction

  genvar g;
  generate
    for (g = 0; g < ils_pkg::NUM_LANES; g++) begin : gen_lane
      ils_lane_capture u_cap (
        .clk      (SYS_CLK),
        .rst      (RST),
        .cfg      (LANE_CFG[g]),
        .rec      (lane_rec[g]),
        .captured (lane_cap[g]),
        .mismatch (lane_mis[g])
      );
    end
  endgenerate

  assign idx       = APB_REQ.paddr[ils_pkg::IDX_W+1:2];
  assign aligned   = (APB_REQ.paddr[1:0] == 2'h0) &&
                     (APB_REQ.paddr[ils_pkg::ADDR_W-1:ils_pkg::IDX_W+2] == '0);
  assign access    = APB_REQ.psel && APB_REQ.penable;
  assign first_acc = access && !s_q.ack;
  assign done      = access && s_q.ack;

  assign m_rx   = lane_match(idx, ils_pkg::IDX_RX_CHK);
  assign m_calc = lane_match(idx, ils_pkg::IDX_CALC_CHK);
  assign m_id   = lane_match(idx, ils_pkg::IDX_RX_IDENT);

  // Read decode; lane and ident registers go through the selected link page
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b0;
    if (aligned) begin
      if (m_rx[3]) begin
        rd_val = widen(lane_rec[m_rx[2:0]][s_q.page].rx_chk);        // R1 R4
        rd_hit = 1'b1;
      end else if (m_calc[3]) begin
        rd_val = widen(lane_rec[m_calc[2:0]][s_q.page].calc_chk);    // R2 R4
        rd_hit = 1'b1;
      end else if (m_id[3]) begin
        rd_val = widen({3'h0, lane_rec[m_id[2:0]][s_q.page].ident}); // R3 R4
        rd_hit = 1'b1;
      end else begin
        case (idx)
          ils_pkg::IDX_LINK_PAGE: begin
            rd_val = {{(ils_pkg::DATA_W-ils_pkg::PAGE_W){1'b0}}, s_q.page};
            rd_hit = 1'b1;
          end
          ils_pkg::IDX_DEV_IDENT: begin
            rd_val = widen(s_q.dev_id[s_q.page]);                    // R5 R4
            rd_hit = 1'b1;
          end
          ils_pkg::IDX_BANK_IDENT: begin
            rd_val = widen(s_q.bank_id[s_q.page]);                   // R6 R4
            rd_hit = 1'b1;
          end
          ils_pkg::IDX_DEFRAMER_CTRL: begin
            rd_val = '0;
            rd_val[ils_pkg::DFR_SRST_BIT] = s_q.dfr_srst;
            rd_hit = 1'b1;
          end
          ils_pkg::IDX_IRQ_STATUS: begin
            rd_val = {{(ils_pkg::DATA_W-ils_pkg::ST_W){1'b0}}, s_q.status};
            rd_hit = 1'b1;
          end
          ils_pkg::IDX_IRQ_MASK: begin
            rd_val = {{(ils_pkg::DATA_W-ils_pkg::ST_W){1'b0}}, s_q.mask};
            rd_hit = 1'b1;
          end
          default: begin
            rd_val = '0;
            rd_hit = 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    s_d = s_q;
    ev  = '0;
    clr = '0;
    ev[ils_pkg::ST_CAPTURE]  = |lane_cap;
    ev[ils_pkg::ST_MISMATCH] = |lane_mis;

    // One wait state so read data comes from a flip-flop
    if (first_acc) begin
      s_d.ack    = 1'b1;
      s_d.rdata  = APB_REQ.pwrite ? '0 : rd_val;
      s_d.slverr = !rd_hit;
    end else if (done) begin
      s_d.ack    = 1'b0;
      s_d.rdata  = '0;
      s_d.slverr = 1'b0;
    end else begin
      s_d.ack    = 1'b0;
    end

    if (done && APB_REQ.pwrite && aligned) begin
      case (idx)
        ils_pkg::IDX_LINK_PAGE: begin
          s_d.page = APB_REQ.pwdata[ils_pkg::PAGE_W-1:0];             // R4
        end
        ils_pkg::IDX_DEV_IDENT: begin
          s_d.dev_id[s_q.page] = APB_REQ.pwdata[ils_pkg::REG_W-1:0];  // R5
        end
        ils_pkg::IDX_BANK_IDENT: begin
          s_d.bank_id[s_q.page] = APB_REQ.pwdata[ils_pkg::REG_W-1:0]; // R6
          // Write still lands; software is told it broke the ordering
          ev[ils_pkg::ST_BID_LATE] = !s_q.dfr_srst;                   // R7 R8
        end
        ils_pkg::IDX_DEFRAMER_CTRL: begin
          s_d.dfr_srst = APB_REQ.pwdata[ils_pkg::DFR_SRST_BIT];
        end
        ils_pkg::IDX_IRQ_MASK: begin
          s_d.mask = APB_REQ.pwdata[ils_pkg::ST_W-1:0];
        end
        default: begin
          s_d.page = s_q.page;
        end
      endcase
    end

    // Clear only what the read reported, so a bit raised meanwhile survives
    if (done && !APB_REQ.pwrite && aligned && idx == ils_pkg::IDX_IRQ_STATUS) begin
      clr = s_q.rdata[ils_pkg::ST_W-1:0];
    end
    s_d.status = (s_q.status & ~clr) | ev;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_q          <= '0;
      s_q.page     <= ils_pkg::RST_LINK_PAGE;
      s_q.dev_id   <= {ils_pkg::NUM_LINKS{ils_pkg::RST_DEV_IDENT}};   // R5
      s_q.bank_id  <= {ils_pkg::NUM_LINKS{ils_pkg::RST_BANK_IDENT}};  // R6
      s_q.dfr_srst <= ils_pkg::RST_DFR_SRST;
      s_q.mask     <= ils_pkg::RST_IRQ_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign APB_RSP.pready  = s_q.ack;
  assign APB_RSP.prdata  = s_q.rdata;
  assign APB_RSP.pslverr = s_q.ack && s_q.slverr;

  assign LINK_DEV_IDENT                = s_q.dev_id;
  assign LINK_BANK_IDENT               = s_q.bank_id;
  assign QUAD_BYTE_DEFRAMER_SOFT_RESET = s_q.dfr_srst;
  assign IRQ                           = |(s_q.status & s_q.mask);

endmodule

// [dv/ils_lane_status_props.sv]
// Port checker for the lane status bank
`timescale 1ns/10ps
module ils_props (
  input wire logic                  SYS_CLK,
  input wire logic                  RST,
  input wire ils_pkg::ils_apb_req_t APB_REQ,
  input wire ils_pkg::ils_apb_rsp_t APB_RSP,
  input wire logic [1:0][7:0]       LINK_DEV_IDENT,
  input wire logic [1:0][7:0]       LINK_BANK_IDENT,
  input wire logic                  QUAD_BYTE_DEFRAMER_SOFT_RESET
);
  wire       wr_c = APB_REQ.pwrite && APB_RSP.pready;
  wire       rd_c = !APB_REQ.pwrite;
  wire [11:0] idx = APB_REQ.paddr[13:2];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence acc_s;
    APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready;
  endsequence
  sequence done_s;
    APB_REQ.psel && APB_REQ.penable && APB_RSP.pready;
  endsequence
  ack_wait_a: assert property (acc_s |=> APB_RSP.pready)
    else $error("ack late");
  bad_addr_a: assert property (done_s and APB_REQ.paddr[1:0] != 2'h0 |-> APB_RSP.pslverr)
    else $error("misaligned not refused");
  ident_rsvd_a: assert property (done_s and rd_c && idx inside {ils_pkg::IDX_RX_IDENT}
    |-> APB_RSP.prdata[31:5] == 27'h0) else $error("ident upper bits set");
  chk_upper_a: assert property (done_s and rd_c && (idx inside {ils_pkg::IDX_RX_CHK} ||
    idx inside {ils_pkg::IDX_CALC_CHK}) |-> APB_RSP.prdata[31:8] == 24'h0) else $error("chk wide");
  srst_init_a: assert property ($fell(RST) |-> QUAD_BYTE_DEFRAMER_SOFT_RESET)
    else $error("soft reset not held");
  ident_init_a: assert property ($fell(RST) |-> {LINK_DEV_IDENT, LINK_BANK_IDENT} == 32'h0)
    else $error("ident not reset");
  dev_write_a: assert property (done_s and wr_c && APB_REQ.paddr == 16'h1140 |=>
    LINK_DEV_IDENT[0] == $past(APB_REQ.pwdata[7:0]) ||
    LINK_DEV_IDENT[1] == $past(APB_REQ.pwdata[7:0])) else $error("dev ident write lost");
  bank_write_a: assert property (done_s and wr_c && APB_REQ.paddr == 16'h1144 |=>
    LINK_BANK_IDENT[0] == $past(APB_REQ.pwdata[7:0]) ||
    LINK_BANK_IDENT[1] == $past(APB_REQ.pwdata[7:0])) else $error("bank ident write lost");
  ident_hold_a: assert property (!wr_c |=> $stable(LINK_DEV_IDENT) && $stable(LINK_BANK_IDENT))
    else $error("ident changed without write");
endmodule
bind ils_lane_status ils_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .LINK_DEV_IDENT(LINK_DEV_IDENT), .LINK_BANK_IDENT(LINK_BANK_IDENT),
  .QUAD_BYTE_DEFRAMER_SOFT_RESET(QUAD_BYTE_DEFRAMER_SOFT_RESET));

// [dv/ils_lane_src.sv]
// Far-end lane source model
`timescale 1ns/10ps
module ils_lane_src (
  input  wire logic                    clk,
  output ils_pkg::ils_lane_cfg_t [4:0] cfg
);
  initial cfg = '0;
  // Fields inverted once valid drops, so a stale bus never passes for a held value
  task automatic send(input int ln, input logic l, input logic [7:0] rx,
                      input logic [7:0] cx, input logic [4:0] id);
    @(posedge clk);
    cfg[ln] <= '{1'b1, l, rx, cx, id};
    @(posedge clk);
    cfg[ln] <= '{1'b0, ~l, ~rx, ~cx, ~id};
  endtask
endmodule

// [dv/ilas_lane_status_and_link_id_test.sv]
// Self-checking bench for the lane status bank
`timescale 1ns/10ps
module ilas_lane_status_and_link_id_test;
  localparam logic [15:0] A_PG = 16'h0C00;
  localparam logic [15:0] A_DEV = 16'h1140;
  localparam logic [15:0] A_BNK = 16'h1144;
  localparam logic [15:0] A_CTL = 16'h11D4;
  localparam logic [15:0] A_ST = 16'h1200;
  localparam logic [15:0] A_MSK = 16'h1204;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  ils_pkg::ils_apb_req_t        req = '0;
  ils_pkg::ils_apb_rsp_t        rsp;
  ils_pkg::ils_lane_cfg_t [4:0] cfg;
  logic [1:0][7:0]              dev;
  logic [1:0][7:0]              bnk;
  logic                         srst;
  logic                         irq;
  int                           error_cnt = 0;
  int                           checks = 0;
  int                           cyc = 0;
  ils_lane_status uut (.SYS_CLK(clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp), .LANE_CFG(cfg),
    .LINK_DEV_IDENT(dev), .LINK_BANK_IDENT(bnk), .QUAD_BYTE_DEFRAMER_SOFT_RESET(srst), .IRQ(irq));
  ils_lane_src src (.clk(clk), .cfg(cfg));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic er);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Waits for the answer; only the bench timeout ends a stall
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    chk({31'h0, rsp.pready}, 32'h1);
    chk(rsp.prdata, e);
    chk({31'h0, rsp.pslverr}, {31'h0, er});
    req <= '0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(ba(ils_pkg::IDX_RX_CHK[i]), 32'h0);
      rd(ba(ils_pkg::IDX_CALC_CHK[i]), 32'h0);
      rd(ba(ils_pkg::IDX_RX_IDENT[i]), 32'h0);
    end
    rd(A_DEV, 32'h0);
    rd(A_BNK, 32'h0);
    rd(A_CTL, 32'h8);
  endtask
  task automatic t_capture();
    for (int i = 0; i < 5; i++) src.send(i, 1'b1, 8'(16 + i), 8'(48 + i), 5'(24 + i));
    wr(A_PG, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd(ba(ils_pkg::IDX_RX_CHK[i]), 32'(16 + i));
      rd(ba(ils_pkg::IDX_CALC_CHK[i]), 32'(48 + i));
      rd(ba(ils_pkg::IDX_RX_IDENT[i]), 32'(24 + i));
    end
    wr(A_PG, 32'h0);
    rd(ba(ils_pkg::IDX_RX_CHK[4]), 32'h0);
    rd(A_ST, 32'h3);
  endtask
  task automatic t_irq();
    wr(A_MSK, 32'h1);
    src.send(0, 1'b0, 8'h5A, 8'h5A, 5'h03);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(A_ST, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h0);
    src.send(1, 1'b0, 8'h11, 8'h22, 5'h04);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(A_ST, 32'h3);
    rd(ba(ils_pkg::IDX_RX_CHK[0]), 32'h5A);
  endtask
  task automatic t_refuse();
    apb(1'b0, 16'h0004, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 16'h1141, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 16'h5140, 32'h55, 32'h0, 1'b1);
    apb(1'b1, ba(ils_pkg::IDX_RX_CHK[0]), 32'hFF, 32'h0, 1'b0);
    rd(ba(ils_pkg::IDX_RX_CHK[0]), 32'h5A);
    rd(A_DEV, 32'h0);
  endtask
  task automatic t_ident();
    wr(A_PG, 32'h1);
    wr(A_DEV, 32'hA5);
    wr(A_BNK, 32'h3C);
    rd(A_DEV, 32'hA5);
    rd(A_BNK, 32'h3C);
    chk({dev, bnk}, 32'hA500_3C00);
    wr(A_CTL, 32'h0);
    @(posedge clk);
    chk({31'h0, srst}, 32'h0);
    wr(A_BNK, 32'h77);
    rd(A_ST, 32'h4);
    wr(A_CTL, 32'h8);
  endtask
  task automatic t_rerst();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({dev, bnk}, 32'h0);
    rd(ba(ils_pkg::IDX_CALC_CHK[0]), 32'h0);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_capture();
    t_irq();
    t_refuse();
    t_ident();
    t_rerst();
    finish_test();
  end
endmodule
